// ==== nst_consts.vh ====
// opcode encodings, field positions and widths for the nibble swap / table read unit
`ifndef NST_CONSTS_VH
`define NST_CONSTS_VH
`define NST_OP_W 16
`define NST_SWAP_MASK 16'h3f00
`define NST_SWAP_CODE 16'h0e00
`define NST_TRH_CODE 16'h0058
`define NST_TRL_CODE 16'h0050
`define NST_D_BIT 7
`define NST_FA_W 9
`define NST_PTRH_W 8
`define NST_ROM_AW 16
`endif

// ==== nst_unit.v ====
// nibble swap and program-memory table read execution unit
`timescale 1ns/10ps
// Overview of operation
// RULE1: swap result exchanges source byte nibbles
// RULE2: destination bit zero writes W, one writes file
// RULE3: nine-bit file address, one-bit destination
// RULE4: high table read loads W and latch
// RULE5: table address is pointer high then low
// RULE6: high table read takes two cycles
// RULE7: low table read loads W and latch
// RULE8: low table read takes two cycles
// RULE9: swap one cycle, no status flags touched
`include "nst_consts.vh"
module nst_unit #(
   parameter PTRH_W = `NST_PTRH_W
)(
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   input wire op_valid,
   input wire [`NST_OP_W-1:0] op_word,
   input wire [7:0] file_rd_data,
   input wire [7:0] table_pointer_high,
   input wire [7:0] table_pointer_low,
   input wire [`NST_ROM_AW-1:0] rom_rd_data,
   output reg op_busy_r,
   output reg op_done_r,
   output reg [`NST_FA_W-1:0] file_addr_r,
   output reg file_we_r,
   output reg [7:0] file_wr_data_r,
   output reg w_we_r,
   output reg [7:0] w_wr_data_r,
   output reg [`NST_ROM_AW-1:0] rom_addr_r,
   output reg rom_rd_r,
   output reg [7:0] table_read_latch_r
);
   localparam ST_IDLE = 1'b0;
   localparam ST_TAB = 1'b1;

   function is_swap;
      input [`NST_OP_W-1:0] w;
      begin
         is_swap = ((w & `NST_SWAP_MASK) == `NST_SWAP_CODE);
      end
   endfunction

   // exact match: table reads carry no operand fields
   function is_table;
      input [`NST_OP_W-1:0] w;
      input hi;
      begin
         if (hi)
         begin
            is_table = (w == `NST_TRH_CODE);
         end
         else
         begin
            is_table = (w == `NST_TRL_CODE);
         end
      end
   endfunction

   reg state_r;
   reg hi_sel_r;
   wire swap_nibbles_op = op_valid && is_swap(op_word);
   wire table_read_high_op = op_valid && is_table(op_word, 1'b1);
   wire table_read_low_op = op_valid && is_table(op_word, 1'b0);
   wire idle = (state_r == ST_IDLE);
   wire in_tab = (state_r == ST_TAB);
   // ops arriving during the second table cycle are dropped
   wire start_swap = idle && swap_nibbles_op;
   wire start_tab = idle && (table_read_high_op || table_read_low_op);
   wire swap_to_file = start_swap && op_word[`NST_D_BIT]; // RULE2
   wire swap_to_w = start_swap && !op_word[`NST_D_BIT]; // RULE2
   // file address: low seven bits plus top bits in 15:14
   wire [`NST_FA_W-1:0] fa =
      {op_word[15:14], op_word[6:0]}; // RULE3
   wire [7:0] swapped;
   wire [`NST_ROM_AW-1:0] table_pointer =
      {table_pointer_high[PTRH_W-1:0], table_pointer_low[7:0]}; // RULE5
   wire [7:0] rom_byte = hi_sel_r ? rom_rd_data[15:8] : rom_rd_data[7:0];

   // each result bit comes from the other nibble
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_swap
         assign swapped[g] = file_rd_data[(g + 4) % 8]; // RULE1
      end
   endgenerate

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= ST_IDLE;
      end
      else if (clk_en)
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (start_tab)
               begin
                  state_r <= ST_TAB;
               end
            end
            ST_TAB:
            begin
               // second cycle completes table read
               state_r <= ST_IDLE; // RULE6 RULE8
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hi_sel_r <= 1'b0;
      end
      else if (clk_en && start_tab)
      begin
         hi_sel_r <= table_read_high_op;
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         op_busy_r <= 1'b0;
      end
      else if (clk_en)
      begin
         op_busy_r <= start_tab;
      end
   end

   // swap finishes in one cycle, table read in two; no flag outputs
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         op_done_r <= 1'b0;
      end
      else if (clk_en)
      begin
         op_done_r <= start_swap || in_tab; // RULE9
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         file_addr_r <= {`NST_FA_W{1'b0}};
      end
      else if (clk_en && start_swap)
      begin
         file_addr_r <= fa; // RULE3
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         file_we_r <= 1'b0;
      end
      else if (clk_en)
      begin
         file_we_r <= swap_to_file; // RULE2
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         file_wr_data_r <= 8'h00;
      end
      else if (clk_en && swap_to_file)
      begin
         file_wr_data_r <= swapped;
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         w_we_r <= 1'b0;
      end
      else if (clk_en)
      begin
         w_we_r <= swap_to_w || in_tab; // RULE2 RULE4 RULE7
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         w_wr_data_r <= 8'h00;
      end
      else if (clk_en)
      begin
         if (swap_to_w)
         begin
            w_wr_data_r <= swapped;
         end
         else if (in_tab)
         begin
            w_wr_data_r <= rom_byte; // RULE4 RULE7
         end
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rom_addr_r <= {`NST_ROM_AW{1'b0}};
      end
      else if (clk_en && start_tab)
      begin
         rom_addr_r <= table_pointer; // RULE5
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rom_rd_r <= 1'b0;
      end
      else if (clk_en)
      begin
         rom_rd_r <= start_tab;
      end
   end

   // latch keeps the last table byte until the next table read
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         table_read_latch_r <= 8'h00;
      end
      else if (clk_en && in_tab)
      begin
         table_read_latch_r <= rom_byte; // RULE4 RULE7
      end
   end
endmodule // nst_unit

// ==== nst_unit_properties.sv ====
// checker for the nibble swap / table read unit
`timescale 1ns/10ps
module nst_unit_properties(input logic clk, sys_rst, clk_en, op_valid,
   input logic [15:0] op_word, input logic op_busy_r, op_done_r, rom_rd_r,
   input logic w_we_r, file_we_r);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire take = clk_en && op_valid && !op_busy_r;
   wire swp = (op_word & 16'h3f00) == 16'h0e00;
   wire trd = op_word == 16'h0058 || op_word == 16'h0050;
   swap_dest_a: assert property (take && swp |=> op_done_r && !op_busy_r &&
      file_we_r == $past(op_word[7]) && w_we_r != file_we_r) else $error("swap");
   trd_start_a: assert property (take && trd |=> rom_rd_r && op_busy_r)
      else $error("table start");
   trd_end_a: assert property (clk_en && rom_rd_r |=> op_done_r && w_we_r)
      else $error("table end");
   busy_one_a: assert property (clk_en && op_busy_r |=> !op_busy_r)
      else $error("busy length");
   done_wr_a: assert property (op_done_r |-> w_we_r || file_we_r)
      else $error("done without write");
   swap_single_a: assert property (take && swp |=> !rom_rd_r)
      else $error("swap took a table cycle");
   trd_no_file_a: assert property (clk_en && rom_rd_r |=> !file_we_r)
      else $error("table read wrote file");
   cover property (file_we_r);
   cover property (w_we_r && !rom_rd_r);
   cover property (op_busy_r);
endmodule // nst_unit_properties
bind nst_unit nst_unit_properties u_nst_unit_properties(.*);

// ==== nst_rom_model.sv ====
// program memory model answering table reads
`timescale 1ns/10ps
module nst_rom_model(input logic clk, rom_rd_r, input logic [15:0] rom_addr_r,
   output logic [15:0] rom_rd_data);
   logic [15:0] pat_r = 16'h5a5a;
   always @(posedge clk) pat_r <= ~pat_r;
   // word shown only while the read strobe stands
   assign rom_rd_data = rom_rd_r ? {rom_addr_r[7:0] ^ 8'ha5,
      rom_addr_r[15:8] + 8'h13} : pat_r;
endmodule // nst_rom_model

// ==== testbench.sv ====
// self-checking bench for the nibble swap / table read unit
`timescale 1ns/10ps
module testbench;
   logic clk = 0, sys_rst = 1, clk_en = 1, op_valid = 0;
   logic [15:0] op_word = 0, rom_rd_data;
   logic [7:0] file_rd_data = 0, e;
   logic [7:0] table_pointer_high = 0, table_pointer_low = 0;
   wire op_busy_r, op_done_r, file_we_r, w_we_r, rom_rd_r;
   wire [8:0] file_addr_r;
   wire [7:0] file_wr_data_r, w_wr_data_r, table_read_latch_r;
   wire [15:0] rom_addr_r;
   int n_fail = 0, cmp_count = 0, i, k;
   nst_unit u_nst_unit(.*);
   nst_rom_model u_nst_rom_model(.*);
   initial forever #2.5 clk = ~clk;
   task stop_test;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [47:0] got, exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function logic [7:0] xb(input logic [15:0] op, input logic [7:0] f, h, l);
      if (op == 16'h0058) return l ^ 8'ha5;
      if (op == 16'h0050) return h + 8'h13;
      return {f[3:0], f[7:4]};
   endfunction
   task run(input logic [15:0] op);
      op_word = op;
      op_valid = 1;
      e = xb(op, file_rd_data, table_pointer_high, table_pointer_low);
      @(posedge clk) #1 op_valid = 0;
      for (i = 0; i < 3 && op_done_r !== 1'b1; i++) @(posedge clk) #1;
      if (!op[11])
         chk({op_done_r, rom_addr_r, table_read_latch_r, w_wr_data_r,
            w_we_r}, {1'b1, table_pointer_high, table_pointer_low, e, e,
            1'b1});
      else
         chk({op_done_r, file_addr_r, file_we_r, w_we_r,
            op[7] ? file_wr_data_r : w_wr_data_r}, {1'b1, op[15:14],
            op[6:0], op[7], !op[7], e});
   endtask
   initial
   begin
      k = $urandom(32'h5c20);
      repeat (8) @(posedge clk);
      #1 sys_rst = 0;
      file_rd_data = 8'ha5;
      run(16'hcebf);
      {table_pointer_high, table_pointer_low} = 16'h0234;
      run(16'h0050);
      run(16'h0058);
      // freeze the unit in the middle of a table read
      op_word = 16'h0058;
      op_valid = 1;
      @(posedge clk) #1 op_valid = 0;
      clk_en = 0;
      repeat (3) @(posedge clk);
      #1 chk({op_done_r, op_busy_r, rom_rd_r}, 3'b011);
      clk_en = 1;
      e = xb(16'h0058, 8'h00, table_pointer_high, table_pointer_low);
      @(posedge clk) #1 chk({op_done_r, op_busy_r, w_wr_data_r}, {2'b10, e});
      repeat (60)
      begin
         {file_rd_data, table_pointer_high, table_pointer_low} = 24'($urandom);
         k = $urandom;
         run(k[0] ? 16'h0058 : k[1] ? 16'h0050 :
            16'($urandom) & 16'hc0ff | 16'h0e00);
      end
      op_word = 16'h0d00;
      op_valid = 1;
      @(posedge clk) #1 op_valid = 0;
      chk({op_done_r, file_we_r, w_we_r}, 0);
      stop_test;
   end
   initial
   begin
      #20000 n_fail++;
      stop_test;
   end
endmodule // testbench
